// ### logic/dssc_map.svh
// Address map, field positions and reset values of the divider start sync control
// Overview of operation
// - Bit 10 clear resynchronizes the divider start to the oscillator clock; set bypasses it.
// - Bit 11 clear runs sync logic only while oscillator or auxiliary clock present.
// - Bit 12 clear holds sync logic until the first lock indication was seen.
// - Bit 13 set gates sync logic on comparison frequency above about 600 kHz.
// - Bit 14 clear presets the reference divider while holdover_request_n is low.
// - Bits 16:15 trim feedback divider bias: 00 none, 01 about 20%, 10 about 30%.
`ifndef DSSC_MAP_SVH
`define DSSC_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define DSSC_ADDR_CONFIG        4'h0
`define DSSC_ADDR_NV_IMAGE      4'h4
`define DSSC_ADDR_COMMAND       4'h8
`define DSSC_ADDR_STATUS        4'hC

// ==========================================================================
// Configuration fields
`define DSSC_BIT_START_BYPASS   10
`define DSSC_BIT_PRESENCE_BP    11
`define DSSC_BIT_LOCK_WAIT_BP   12
`define DSSC_BIT_LOW_FREQ_EN    13
`define DSSC_BIT_PRESET_DIS     14
`define DSSC_BIT_TRIM_LO        15
`define DSSC_BIT_TRIM_HI        16
`define DSSC_CONFIG_MASK        32'h0001FC00
`define DSSC_CONFIG_RESET       32'h00000000
// Synchronizer reset levels {hold_n, freq, lock, aux, osc, start}; hold_n idles high,
// so a zero reset would fake a holdover and preset the reference divider
`define DSSC_SYNC_INIT          6'h20

// ==========================================================================
// Command bits (write only, self clearing)
`define DSSC_CMD_STORE          0
`define DSSC_CMD_RELOAD         1
`define DSSC_CMD_CLEAR_LOCK     2

// ==========================================================================
// Status bits
`define DSSC_STS_RUNNING        0
`define DSSC_STS_LOCK_SEEN      1
`define DSSC_STS_CLOCKS_OK      2
`define DSSC_STS_FREQ_OK        3
`define DSSC_STS_PRESET         4
`define DSSC_STS_START          5
`define DSSC_STS_HOLD_N         6
`define DSSC_STS_LOCK           7

// ==========================================================================
// Bias trim codes
`define DSSC_TRIM_NONE          2'h0
`define DSSC_TRIM_20PCT         2'h1
`define DSSC_TRIM_30PCT         2'h2

// AXI responses
`define DSSC_RESP_OKAY          2'h0
`define DSSC_RESP_SLVERR        2'h2

`endif

// ### logic/dssc_pkg.sv
// Types shared by the divider start sync control
package dssc_pkg;

  typedef enum logic [1:0] {
    DSSC_ST_WAIT = 2'h1,
    DSSC_ST_RUN  = 2'h2
  } dssc_state_t;

endpackage

// ### logic/dssc_sync3.sv
// Three-stage input synchronizer that accepts a change once stages two and three agree
`timescale 1ns/1ns
module dssc_sync3 #(
  parameter int           W    = 1,
  // Reset value per bit; should match each pin's idle level
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // ==========================================================================
  // Agreement filter
  // Stage one is read only by stage two; the filter looks at two and three
  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg  <= INIT;
      s2_reg  <= INIT;
      s3_reg  <= INIT;
      out_reg <= INIT;
    end else begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule

// ### logic/dssc_top.sv
// Divider start sync control with AXI4-Lite configuration registers
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "dssc_map.svh"
module dssc_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Pins sampled from outside the clock domain
  input  wire logic        divider_start,
  input  wire logic        osc_clock_present,
  input  wire logic        aux_clock_present,
  input  wire logic        pll_lock,
  input  wire logic        comp_freq_above,
  input  wire logic        holdover_request_n,
  // Divider controls
  output logic             divider_release,
  output logic             ref_divider_preset,
  output logic [1:0]       feedback_divider_bias_trim,
  output logic             bias_reduce_20pct,
  output logic             bias_reduce_30pct
);

  localparam int NSYNC = 6;

  // ==========================================================================
  // Input synchronizers
  logic [NSYNC-1:0] pins_sync;
  logic             start_sync;
  logic             osc_sync;
  logic             aux_sync;
  logic             lock_sync;
  logic             freq_sync;
  logic             hold_n_sync;

  dssc_sync3 #(
    .W    (NSYNC),
    .INIT (`DSSC_SYNC_INIT)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({holdover_request_n, comp_freq_above, pll_lock,
                aux_clock_present, osc_clock_present, divider_start}),
    .sync_out (pins_sync)
  );

  assign start_sync  = pins_sync[0];
  assign osc_sync    = pins_sync[1];
  assign aux_sync    = pins_sync[2];
  assign lock_sync   = pins_sync[3];
  assign freq_sync   = pins_sync[4];
  assign hold_n_sync = pins_sync[5];

  // ==========================================================================
  // State
  logic                 aw_have_reg, aw_have_next;
  logic [3:0]           aw_addr_reg, aw_addr_next;
  logic                 w_have_reg, w_have_next;
  logic [31:0]          w_data_reg, w_data_next;
  logic [3:0]           w_strb_reg, w_strb_next;
  logic                 bvalid_reg, bvalid_next;
  logic [1:0]           bresp_reg, bresp_next;
  logic                 rvalid_reg, rvalid_next;
  logic [31:0]          rdata_reg, rdata_next;
  logic [1:0]           rresp_reg, rresp_next;
  logic [31:0]          cfg_reg, cfg_next;
  logic [31:0]          nv_reg, nv_next;
  logic                 lock_seen_reg, lock_seen_next;
  logic                 start_raw_reg, start_raw_next;
  logic                 release_reg, release_next;
  logic                 preset_reg, preset_next;
  logic [1:0]           trim_reg, trim_next;
  logic                 red20_reg, red20_next;
  logic                 red30_reg, red30_next;
  dssc_pkg::dssc_state_t state_reg, state_next;

  logic        do_write;
  logic        lock_clear;
  logic        clocks_ok;
  logic        lock_ok;
  logic        freq_ok;
  logic        gate_open;
  logic        start_sel;
  logic [31:0] status_word;

  // Byte lanes merge under the write strobes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================================
  // Gating conditions
  always_comb begin
    clocks_ok = cfg_reg[`DSSC_BIT_PRESENCE_BP] | osc_sync | aux_sync;
    lock_ok   = cfg_reg[`DSSC_BIT_LOCK_WAIT_BP] | lock_seen_reg;
    freq_ok   = ~cfg_reg[`DSSC_BIT_LOW_FREQ_EN] | freq_sync;
    gate_open = clocks_ok & lock_ok & freq_ok;
    // Bypass takes the pin through a single capture flop only, so the
    // release may follow a metastable sample; meant for diagnostics
    start_sel = cfg_reg[`DSSC_BIT_START_BYPASS] ? start_raw_reg : start_sync;
  end

  always_comb begin
    status_word                      = 32'h00000000;
    status_word[`DSSC_STS_RUNNING]   = release_reg;
    status_word[`DSSC_STS_LOCK_SEEN] = lock_seen_reg;
    status_word[`DSSC_STS_CLOCKS_OK] = clocks_ok;
    status_word[`DSSC_STS_FREQ_OK]   = freq_ok;
    status_word[`DSSC_STS_PRESET]    = preset_reg;
    status_word[`DSSC_STS_START]     = start_sel;
    status_word[`DSSC_STS_HOLD_N]    = hold_n_sync;
    status_word[`DSSC_STS_LOCK]      = lock_sync;
  end

  // ==========================================================================
  // AXI4-Lite slave
  assign s_axi_awready = ~aw_have_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_have_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign do_write      = aw_have_reg & w_have_reg & ~bvalid_reg;

  always_comb begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next  = w_have_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    cfg_next     = cfg_reg;
    nv_next      = nv_reg;
    lock_clear   = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `DSSC_RESP_OKAY;
      unique case ({aw_addr_reg[3:2], 2'h0})
        `DSSC_ADDR_CONFIG: begin
          cfg_next = merge_bytes(cfg_reg, w_data_reg, w_strb_reg) & `DSSC_CONFIG_MASK;
        end
        `DSSC_ADDR_COMMAND: begin
          if (w_strb_reg[0]) begin
            if (w_data_reg[`DSSC_CMD_STORE]) begin
              nv_next = cfg_reg;
            end
            if (w_data_reg[`DSSC_CMD_RELOAD]) begin
              cfg_next = nv_reg & `DSSC_CONFIG_MASK;
            end
            lock_clear = w_data_reg[`DSSC_CMD_CLEAR_LOCK];
          end
        end
        default: begin
          bresp_next = `DSSC_RESP_SLVERR;
        end
      endcase
      if (aw_addr_reg[1:0] != 2'h0) begin
        bresp_next = `DSSC_RESP_SLVERR;
        cfg_next   = cfg_reg;
        nv_next    = nv_reg;
        lock_clear = 1'b0;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = `DSSC_RESP_OKAY;
      rdata_next  = 32'h00000000;
      unique case ({s_axi_araddr[3:2], 2'h0})
        `DSSC_ADDR_CONFIG:   rdata_next = cfg_reg;
        `DSSC_ADDR_NV_IMAGE: rdata_next = nv_reg;
        `DSSC_ADDR_STATUS:   rdata_next = status_word;
        default:             rdata_next = 32'h00000000;
      endcase
      if (s_axi_araddr[1:0] != 2'h0) begin
        rresp_next = `DSSC_RESP_SLVERR;
        rdata_next = 32'h00000000;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // ==========================================================================
  // Start release sequencing
  always_comb begin
    start_raw_next = divider_start;
    // A new lock wins over a clear arriving in the same cycle
    lock_seen_next = lock_sync | (lock_seen_reg & ~lock_clear);
    state_next     = state_reg;
    unique case (state_reg)
      dssc_pkg::DSSC_ST_WAIT: begin
        if (gate_open && start_sel) begin
          state_next = dssc_pkg::DSSC_ST_RUN;
        end
      end
      dssc_pkg::DSSC_ST_RUN: begin
        if (!gate_open || !start_sel) begin
          state_next = dssc_pkg::DSSC_ST_WAIT;
        end
      end
      default: begin
        state_next = dssc_pkg::DSSC_ST_WAIT;
      end
    endcase
    release_next = (state_next == dssc_pkg::DSSC_ST_RUN);
    preset_next  = ~cfg_reg[`DSSC_BIT_PRESET_DIS] & ~hold_n_sync;
    trim_next    = cfg_reg[`DSSC_BIT_TRIM_HI:`DSSC_BIT_TRIM_LO];
    // Code 11 is undefined and is treated as no reduction
    red20_next   = (trim_next == `DSSC_TRIM_20PCT);
    red30_next   = (trim_next == `DSSC_TRIM_30PCT);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      aw_addr_reg   <= 4'h0;
      w_have_reg    <= 1'b0;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= `DSSC_RESP_OKAY;
      rvalid_reg    <= 1'b0;
      rdata_reg     <= 32'h00000000;
      rresp_reg     <= `DSSC_RESP_OKAY;
      cfg_reg       <= `DSSC_CONFIG_RESET;
      lock_seen_reg <= 1'b0;
      start_raw_reg <= 1'b0;
      release_reg   <= 1'b0;
      preset_reg    <= 1'b0;
      trim_reg      <= `DSSC_TRIM_NONE;
      red20_reg     <= 1'b0;
      red30_reg     <= 1'b0;
      state_reg     <= dssc_pkg::DSSC_ST_WAIT;
    end else begin
      aw_have_reg   <= aw_have_next;
      aw_addr_reg   <= aw_addr_next;
      w_have_reg    <= w_have_next;
      w_data_reg    <= w_data_next;
      w_strb_reg    <= w_strb_next;
      bvalid_reg    <= bvalid_next;
      bresp_reg     <= bresp_next;
      rvalid_reg    <= rvalid_next;
      rdata_reg     <= rdata_next;
      rresp_reg     <= rresp_next;
      cfg_reg       <= cfg_next;
      lock_seen_reg <= lock_seen_next;
      start_raw_reg <= start_raw_next;
      release_reg   <= release_next;
      preset_reg    <= preset_next;
      trim_reg      <= trim_next;
      red20_reg     <= red20_next;
      red30_reg     <= red30_next;
      state_reg     <= state_next;
    end
  end

  // Nonvolatile image: deliberately untouched by reset so stored settings survive
  always_ff @(posedge aclk) begin
    nv_reg <= nv_next;
  end

  // ==========================================================================
  // Outputs
  assign s_axi_bvalid               = bvalid_reg;
  assign s_axi_bresp                = bresp_reg;
  assign s_axi_rvalid               = rvalid_reg;
  assign s_axi_rdata                = rdata_reg;
  assign s_axi_rresp                = rresp_reg;
  assign divider_release            = release_reg;
  assign ref_divider_preset         = preset_reg;
  assign feedback_divider_bias_trim = trim_reg;
  assign bias_reduce_20pct          = red20_reg;
  assign bias_reduce_30pct          = red30_reg;

endmodule

// ### tb/dssc_top_asserts.sv
// Port-level assertion checker for the divider start sync control
`timescale 1ns/1ns
module dssc_asserts (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pins and divider controls
  input wire logic        divider_start,
  input wire logic        holdover_request_n,
  input wire logic        divider_release,
  input wire logic        ref_divider_preset,
  input wire logic [1:0]  feedback_divider_bias_trim,
  input wire logic        bias_reduce_20pct,
  input wire logic        bias_reduce_30pct
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Sequences
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_start_quiet;
    !divider_start [*6];
  endsequence
  // ==========================================================
  // Properties
  AST_WR_ANSWER: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after transfer");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_TRIM_DECODE: assert property ($stable(feedback_divider_bias_trim) |->
    bias_reduce_20pct == (feedback_divider_bias_trim == 2'h1) &&
    bias_reduce_30pct == (feedback_divider_bias_trim == 2'h2))
    else $error("bias reduction decode wrong");
  AST_PRESET_CAUSE: assert property ($rose(ref_divider_preset) |->
    !$past(holdover_request_n, 3) || !$past(holdover_request_n, 4) ||
    !$past(holdover_request_n, 5))
    else $error("preset without holdover");
  // Synchronizer latency lets the rise trail the start pin by five edges; the check looks back four
  AST_REL_CAUSE: assert property ($rose(divider_release) |-> $past(divider_start) ||
    $past(divider_start, 2) || $past(divider_start, 3) || $past(divider_start, 4))
    else $error("release without start");
  AST_REL_IDLE: assert property (s_start_quiet |-> !divider_release)
    else $error("release held without start");
endmodule

bind dssc_top dssc_asserts i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .divider_start, .holdover_request_n,
  .divider_release, .ref_divider_preset, .feedback_divider_bias_trim, .bias_reduce_20pct,
  .bias_reduce_30pct);

// ### tb/tb_top.sv
// Self-checking testbench for the divider start sync control
`timescale 1ns/1ns
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        divider_start = 1'b0, osc_clock_present = 1'b0, aux_clock_present = 1'b0;
  logic        pll_lock = 1'b0, comp_freq_above = 1'b0, holdover_request_n = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        divider_release, ref_divider_preset, bias_reduce_20pct, bias_reduce_30pct;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp, feedback_divider_bias_trim;
  int          n_fail = 0, checked = 0;

  always #20 aclk = ~aclk;

  dssc_top i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .divider_start, .osc_clock_present, .aux_clock_present, .pll_lock, .comp_freq_above,
    .holdover_request_n, .divider_release, .ref_divider_preset, .feedback_divider_bias_trim,
    .bias_reduce_20pct, .bias_reduce_30pct);

  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    s_axi_bready <= 1'b1;
    do @(negedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // Eight edges cover the five-edge pin-to-output path with margin
  task automatic settle;
    repeat (8) @(negedge aclk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd(4'h0, 32'h0, 2'h0);
    wr(4'h0, 32'hFFFFFFFF, 2'h0);
    rd(4'h0, 32'h0001FC00, 2'h0);
    wr(4'h8, 32'h1, 2'h0);
    rd(4'h4, 32'h0001FC00, 2'h0);
    wr(4'h0, 32'h0, 2'h0);
    wr(4'h8, 32'h2, 2'h0);
    rd(4'h0, 32'h0001FC00, 2'h0);
    wr(4'h4, 32'h0, 2'h2);
    rd(4'h2, 32'h0, 2'h2);
    rd(4'h8, 32'h0, 2'h0);
  endtask

  task automatic t_trim;
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, 32'(i) << 15, 2'h0);
      settle();
      chk(feedback_divider_bias_trim, i);
      chk(bias_reduce_20pct, i == 1);
      chk(bias_reduce_30pct, i == 2);
      @(posedge aclk);
    end
  endtask

  task automatic meas(output int n);
    divider_start <= 1'b0;
    repeat (8) @(posedge aclk);
    divider_start <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!divider_release && n < 20);
    @(posedge aclk);
  endtask

  task automatic t_start;
    int n0, n1;
    wr(4'h0, 32'h00001800, 2'h0);
    meas(n0);
    wr(4'h0, 32'h00001C00, 2'h0);
    meas(n1);
    chk(n0 - n1, 3);
  endtask

  // Pins are {osc, aux, lock, freq}; start stays high from t_start
  task automatic gate(input logic [31:0] cfg, input logic [3:0] p, input logic e);
    {osc_clock_present, aux_clock_present, pll_lock, comp_freq_above} <= p;
    wr(4'h0, cfg, 2'h0);
    settle();
    chk(divider_release, e);
    @(posedge aclk);
  endtask

  task automatic t_gate;
    gate(32'h0800, 4'h0, 1'b0);
    gate(32'h1000, 4'h0, 1'b0);
    gate(32'h1000, 4'h4, 1'b1);
    gate(32'h1000, 4'h8, 1'b1);
    gate(32'h1800, 4'h0, 1'b1);
    gate(32'h3800, 4'h0, 1'b0);
    gate(32'h3800, 4'h1, 1'b1);
    gate(32'h3800, 4'h0, 1'b0);
    gate(32'h0800, 4'h2, 1'b1);
    gate(32'h0800, 4'h0, 1'b1);
    wr(4'h8, 32'h4, 2'h0);
    gate(32'h0800, 4'h0, 1'b0);
  endtask

  task automatic t_preset;
    holdover_request_n <= 1'b0;
    wr(4'h0, 32'h0, 2'h0);
    settle();
    chk(ref_divider_preset, 1'b1);
    @(posedge aclk);
    rd(4'hC, 32'h00000038, 2'h0);
    wr(4'h0, 32'h00004000, 2'h0);
    settle();
    chk(ref_divider_preset, 1'b0);
    @(posedge aclk);
    holdover_request_n <= 1'b1;
    wr(4'h0, 32'h0, 2'h0);
    settle();
    chk(ref_divider_preset, 1'b0);
    @(posedge aclk);
  endtask

  task automatic end_sim;
    $display("checked %0d, n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_trim();
    t_start();
    t_gate();
    t_preset();
    end_sim();
  end
endmodule
